//--- shared/lhc_pkg.sv
// constants and carrier types for the host control flag bank
package lhc_pkg;

	// register bus
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_SET = 12'h050;
	localparam logic [ADDR_W-1:0] OFS_CLR = 12'h054;

	// flag positions
	localparam int POS_IMG_OK = 31;
	localparam int POS_SWAP   = 30;
	localparam int POS_LATE   = 29;
	localparam int POS_OWNER  = 23;
	localparam int POS_CONN   = 17;

	// values after reset
	localparam logic RST_IMG_OK = 1'b0;
	localparam logic RST_SWAP   = 1'b0;
	localparam logic RST_LATE   = 1'b0;
	localparam logic RST_CONN   = 1'b0;
	localparam logic RST_OWNER  = 1'b0;
	localparam logic DEF_OWNER  = 1'b1;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// acknowledge codes sent back to a remote node
	localparam logic [3:0] ACK_NONE     = 4'h0;
	localparam logic [3:0] ACK_PENDING  = 4'h2;
	localparam logic [3:0] ACK_TARDY    = 4'hb;
	localparam logic [3:0] ACK_TYPE_ERR = 4'he;

	// inbound asynchronous request, one-cycle pulses
	typedef struct packed {
		logic romBlockRead;  // block read to host configuration rom
		logic ownAsync;      // any other async packet to this node
	} lhc_req_t;

	// acknowledge decision
	typedef struct packed {
		logic       valid;
		logic [3:0] code;
	} lhc_ack_t;

	// request disposition
	typedef enum logic [1:0] {
		DISP_DROP  = 2'b00,
		DISP_SERVE = 2'b01,
		DISP_ERROR = 2'b10,
		DISP_TARDY = 2'b11
	} lhc_disp_t;

endpackage

//--- design/lhc_flags.sv
// host controller control flag bank with set/clear addresses
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RULE_01) one flag register is reached through a set address and a clear address
// (RULE_02) ones set or clear flags, zeros do nothing, both addresses read flags
// (RULE_03) image valid lets the physical unit serve rom block reads and updates
// (RULE_04) image valid low answers rom block reads with ack_type_error
// (RULE_05) bus reset with image valid low leaves rom mapping registers unchanged
// (RULE_06) software builds the bus info image before setting image valid
// (RULE_07) image valid can only be set while node connect is low
// (RULE_08) image valid cleared by system reset, software reset or fetch error
// (RULE_09) swap bypass selects byte swapping of dma and outside physical data
// (RULE_10) late acknowledge permitted lets accesses, rom reads included, get ack_tardy
// (RULE_11) with late acknowledge, all other async packets to this node get ack_tardy
// (RULE_12) every ack_tardy sent raises the ack_tardy event
// (RULE_13) software clears and unmasks wake events before low power state
// (RULE_14) software keeps late acknowledge off while acting as bus manager
// (RULE_15) bits 28 to 24 read as zero
// (RULE_16) bit 23 is a read-only phy feature owner flag
// (RULE_17) software handles phy enhancements only when owner flag is one
// (RULE_18) owner flag loads from serial eeprom and defaults to one
// (RULE_19) owner flag cleared only by global reset, not system or software reset
// (RULE_20) node connect cleared by resets; while low the node ignores the bus (the code drops requests, but a bus reset still loads rom regs)
module lhc_flags (
	input  wire logic                      mclk,          // 125 MHz clock
	input  wire logic                      rst,           // system reset, sync, high
	input  wire logic                      ce,            // clock enable
	input  wire logic                      softReset,     // software reset level
	input  wire logic                      global_reset_n,// global reset pin, low
	input  wire logic                      eepromLoad,    // owner value strobe
	input  wire logic                      eepromOwner,   // owner value from eeprom
	input  wire logic [lhc_pkg::ADDR_W-1:0] regAddr,      // byte address
	input  wire logic [31:0]               regWrData,     // write data
	input  wire logic                      regWr,         // write strobe
	input  wire logic                      regRd,         // read strobe
	output logic      [31:0]               regRdData,     // read data, next cycle
	input  wire lhc_pkg::lhc_req_t         linkReq,       // inbound request pulses
	input  wire logic                      busReset,      // 1394 bus reset pulse
	input  wire logic                      fetchErr,      // bus info fetch error
	output lhc_pkg::lhc_ack_t              linkAck,       // acknowledge to send
	output logic                           romServe,      // start rom block read
	output logic                           reqForward,    // pass request onward
	output logic                           tardyEvent,    // ack_tardy event pulse
	output logic                           romRegsLoad,   // update rom regs on reset
	output logic                           romUpdateOn,   // atomic rom update enabled
	output logic                           swapBypass,    // no byte swap of data
	output logic                           nodeConnect,   // link connected
	output logic                           phyOwner       // phy feature owner flag
);
	import lhc_pkg::*;

	logic      imgOk;
	logic      lateAck;
	logic      ownerFlag;
	logic      gr1;
	logic      gr2;
	logic      gr3;
	logic      grstOn;
	logic      grstPrev;
	logic      anyReset;
	logic      wrSet;
	logic      wrClr;
	logic      rdHit;
	logic [31:0] flags;
	lhc_disp_t disp;
	logic      reqAny;

	// software reset clears the same state as a system reset, except read data, which only system reset clears
	assign anyReset = rst | softReset;

	// decode
	always_comb begin
		wrSet = 1'b0;
		wrClr = 1'b0;
		rdHit = 1'b0;
		if (regAddr == OFS_SET) begin
			wrSet = regWr; // [RULE_01]
			rdHit = regRd;
		end else if (regAddr == OFS_CLR) begin
			wrClr = regWr; // [RULE_01]
			rdHit = regRd;
		end
	end

	// read image; everything unlisted, 28..24 included, reads as zero
	always_comb begin
		flags = 32'h0000_0000; // [RULE_15]
		flags[POS_IMG_OK] = imgOk;
		flags[POS_SWAP] = swapBypass;
		flags[POS_LATE] = lateAck;
		flags[POS_OWNER] = ownerFlag; // [RULE_16]
		flags[POS_CONN] = nodeConnect;
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdData <= RST_RDATA;
		end else if (ce) begin
			if (rdHit) begin
				regRdData <= flags; // [RULE_02]
			end else begin
				regRdData <= RST_RDATA;
			end
		end
	end

	// image valid: set only while disconnected, hardware fetch error clears it
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			imgOk <= RST_IMG_OK; // [RULE_08]
		end else if (ce) begin
			if (fetchErr) begin
				imgOk <= 1'b0; // [RULE_08]
			end else if (wrSet && regWrData[POS_IMG_OK] && !nodeConnect) begin
				imgOk <= 1'b1; // [RULE_07]
			end
		end
	end

	// swap bypass
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			swapBypass <= RST_SWAP;
		end else if (ce) begin
			if (wrSet && regWrData[POS_SWAP]) begin
				swapBypass <= 1'b1; // [RULE_02] [RULE_09]
			end else if (wrClr && regWrData[POS_SWAP]) begin
				swapBypass <= 1'b0; // [RULE_02] [RULE_09]
			end
		end
	end

	// late acknowledge permit
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			lateAck <= RST_LATE;
		end else if (ce) begin
			if (wrSet && regWrData[POS_LATE]) begin
				lateAck <= 1'b1; // [RULE_02]
			end else if (wrClr && regWrData[POS_LATE]) begin
				lateAck <= 1'b0; // [RULE_02]
			end
		end
	end

	// node connect
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			nodeConnect <= RST_CONN; // [RULE_20]
		end else if (ce) begin
			if (wrSet && regWrData[POS_CONN]) begin
				nodeConnect <= 1'b1; // [RULE_02]
			end else if (wrClr && regWrData[POS_CONN]) begin
				nodeConnect <= 1'b0; // [RULE_02]
			end
		end
	end

	// global reset pin: three stages, a change counts when stages two and three agree
	// system reset stays out of this path, else a pin held low during it would go unseen
	always_ff @(posedge mclk) begin
		if (ce) begin
			gr1 <= global_reset_n;
			gr2 <= gr1;
			gr3 <= gr2;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce) begin
			if (gr2 == gr3) begin
				grstOn <= ~gr3;
			end
			grstPrev <= grstOn;
		end
	end

	// owner flag ignores system and software reset; it must see a global reset once
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (grstOn) begin
				ownerFlag <= RST_OWNER; // [RULE_19]
			end else if (eepromLoad) begin
				ownerFlag <= eepromOwner; // [RULE_18]
			end else if (grstPrev) begin
				ownerFlag <= DEF_OWNER; // [RULE_18]
			end
		end
	end

	assign phyOwner = ownerFlag;
	assign romUpdateOn = imgOk; // [RULE_03]

	// a disconnected node drops every request without any answer
	assign reqAny = linkReq.romBlockRead | linkReq.ownAsync;

	always_comb begin
		disp = DISP_DROP;
		if (!nodeConnect) begin
			disp = DISP_DROP; // [RULE_20]
		end else if (lateAck && reqAny) begin
			disp = DISP_TARDY; // [RULE_10] [RULE_11]
		end else if (linkReq.romBlockRead) begin
			if (imgOk) begin
				disp = DISP_SERVE; // [RULE_03]
			end else begin
				disp = DISP_ERROR; // [RULE_04]
			end
		end else if (linkReq.ownAsync) begin
			disp = DISP_SERVE;
		end
	end

	// acknowledge and side effects, registered one cycle after the request
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			linkAck <= '{valid: 1'b0, code: ACK_NONE};
			romServe <= 1'b0;
			reqForward <= 1'b0;
			tardyEvent <= 1'b0;
		end else if (ce) begin
			linkAck <= '{valid: 1'b0, code: ACK_NONE};
			romServe <= 1'b0;
			reqForward <= 1'b0;
			tardyEvent <= 1'b0;
			case (disp)
				DISP_TARDY: begin
					linkAck <= '{valid: 1'b1, code: ACK_TARDY}; // [RULE_11]
					tardyEvent <= 1'b1; // [RULE_12]
				end
				DISP_ERROR: begin
					linkAck <= '{valid: 1'b1, code: ACK_TYPE_ERR}; // [RULE_04]
				end
				DISP_SERVE: begin
					linkAck <= '{valid: 1'b1, code: ACK_PENDING};
					romServe <= linkReq.romBlockRead; // [RULE_03]
					reqForward <= ~linkReq.romBlockRead;
				end
				default: begin
					linkAck <= '{valid: 1'b0, code: ACK_NONE};
				end
			endcase
		end
	end

	// rom mapping, header and bus options only reload on bus reset with a valid image
	always_ff @(posedge mclk) begin
		if (anyReset) begin
			romRegsLoad <= 1'b0;
		end else if (ce) begin
			romRegsLoad <= busReset & imgOk; // [RULE_05]
		end
	end

endmodule

`default_nettype wire

//--- verif/lhc_flags_sva.sv
// port assertions for the host control flag bank
`timescale 1ns/1ps
`default_nettype none
module lhc_flags_sva
	import lhc_pkg::*;
(
	input wire logic                  mclk,        // clock
	input wire logic                  rst,         // reset
	input wire logic                  ce,          // enable
	input wire logic                  softReset,   // sw reset
	input wire logic [ADDR_W-1:0]     regAddr,     // address
	input wire logic [31:0]           regWrData,   // wdata
	input wire logic                  regWr,       // write
	input wire logic                  regRd,       // read
	input wire logic [31:0]           regRdData,   // rdata
	input wire lhc_pkg::lhc_req_t     linkReq,     // requests
	input wire logic                  busReset,    // bus reset
	input wire logic                  fetchErr,    // fetch error
	input wire lhc_pkg::lhc_ack_t     linkAck,     // ack
	input wire logic                  romServe,    // rom read
	input wire logic                  tardyEvent,  // tardy event
	input wire logic                  romRegsLoad, // rom regs load
	input wire logic                  romUpdateOn, // image valid
	input wire logic                  swapBypass,  // swap bypass
	input wire logic                  nodeConnect  // connected
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_req;
		ce && !softReset && nodeConnect && (linkReq.romBlockRead || linkReq.ownAsync);
	endsequence
	a_ack_next: assert property (s_req |=> linkAck.valid) else $error("request not acknowledged");
	a_idle_link: assert property (ce && !nodeConnect |=> !linkAck.valid && !romServe)
		else $error("answer while disconnected");
	a_tardy_event: assert property (linkAck.valid && linkAck.code == ACK_TARDY |-> tardyEvent)
		else $error("tardy ack without event");
	a_type_error: assert property (linkAck.code == ACK_TYPE_ERR |-> !$past(romUpdateOn))
		else $error("type error with image valid");
	a_rom_serve: assert property (romServe |-> linkAck.code == ACK_PENDING && $past(romUpdateOn))
		else $error("rom served without image valid");
	a_img_blocked: assert property (ce && regWr && regAddr == OFS_SET && nodeConnect && !romUpdateOn
		|=> !romUpdateOn) else $error("image valid set while connected");
	a_fetch_clear: assert property (ce && fetchErr |=> !romUpdateOn) else $error("fetch error kept image");
	a_soft_clear: assert property (ce && softReset |=> !nodeConnect && !romUpdateOn)
		else $error("soft reset kept flags");
	a_bus_reset: assert property (ce && busReset |=> romRegsLoad == $past(romUpdateOn))
		else $error("rom regs load wrong");
	a_rsvd_zero: assert property (regRdData[28:24] == 5'h00 && regRdData[15:0] == 16'h0000)
		else $error("reserved bits set");
	a_read_flags: assert property (ce && regRd && !softReset && (regAddr == OFS_SET || regAddr == OFS_CLR)
		|=> regRdData[POS_SWAP] == swapBypass && regRdData[POS_CONN] == nodeConnect)
		else $error("read flags wrong");
	a_read_idle: assert property (ce && !regRd |=> regRdData == 32'h0000_0000) else $error("stray read data");
endmodule
bind lhc_flags lhc_flags_sva chk (.mclk, .rst, .ce, .softReset, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
	.linkReq, .busReset, .fetchErr, .linkAck, .romServe, .tardyEvent, .romRegsLoad, .romUpdateOn, .swapBypass,
	.nodeConnect);
`default_nettype wire

//--- verif/lhc_remote_node.sv
// remote node stand-in: inbound request pulses and bus resets
`timescale 1ns/1ps
`default_nettype none
module lhc_remote_node
	import lhc_pkg::*;
(
	input wire logic  mclk,     // clock
	output lhc_req_t  linkReq,  // request pulses
	output logic      busReset  // bus reset pulse
);
	initial begin
		linkReq = '0;
		busReset = 1'b0;
	end
	task automatic send(input logic rom, input logic own);
		@(posedge mclk);
		linkReq <= '{romBlockRead: rom, ownAsync: own};
		@(posedge mclk);
		linkReq <= '0;
	endtask
	task automatic reset_bus;
		@(posedge mclk);
		busReset <= 1'b1;
		@(posedge mclk);
		busReset <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the host control flag bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lhc_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
	logic             mclk, rst, ce, softReset, global_reset_n, eepromLoad, eepromOwner;
	logic             regWr, regRd, busReset, fetchErr, romServe, reqForward, tardyEvent;
	logic             romRegsLoad, romUpdateOn, swapBypass, nodeConnect, phyOwner;
	logic [ADDR_W-1:0] regAddr;
	logic [31:0]      regWrData, regRdData;
	lhc_req_t         linkReq;
	lhc_ack_t         linkAck;
	int               error_cnt = 0;
	int               check_count = 0;
	lhc_flags dut (.mclk, .rst, .ce, .softReset, .global_reset_n, .eepromLoad, .eepromOwner, .regAddr, .regWrData,
		.regWr, .regRd, .regRdData, .linkReq, .busReset, .fetchErr, .linkAck, .romServe, .reqForward, .tardyEvent,
		.romRegsLoad, .romUpdateOn, .swapBypass, .nodeConnect, .phyOwner);
	lhc_remote_node node (.mclk, .linkReq, .busReset);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask
	// answer pattern is {ack, romServe, reqForward, tardyEvent}
	task automatic ack(input logic rom, input logic own, input logic [7:0] e);
		node.send(rom, own);
		#1 `CHK({linkAck, romServe, reqForward, tardyEvent}, e)
	endtask
	task automatic wait_owner;
		for (int i = 0; i < 10 && phyOwner !== 1'b1; i++) @(posedge mclk);
		`CHK(phyOwner, 1'b1)
		if (phyOwner !== 1'b1) begin
			finish_test();
		end
	endtask
	task automatic t_bits;
		wait_owner(); // phy bits are only touched once the owner flag is up
		rd(OFS_SET, 32'h0080_0000);
		wr(OFS_SET, 32'hffff_ffff);
		rd(OFS_CLR, 32'he082_0000);
		`CHK(swapBypass, 1'b1)
		wr(OFS_CLR, 32'h0080_0000);
		wr(12'h058, 32'hffff_ffff);
		rd(12'h058, 32'h0000_0000);
		rd(OFS_SET, 32'he082_0000);
		wr(OFS_CLR, 32'hffff_ffff);
		// image valid cannot be cleared from software, only by resets or a fetch error
		rd(OFS_SET, 32'h8080_0000);
	endtask
	task automatic t_link;
		wr(OFS_SET, 32'h8002_0000); // image assumed built beforehand
		ack(1'b1, 1'b0, {1'b1, ACK_PENDING, 3'b100});
		ack(1'b0, 1'b1, {1'b1, ACK_PENDING, 3'b010});
		ack(1'b1, 1'b1, {1'b1, ACK_PENDING, 3'b100});
		node.reset_bus();
		#1 `CHK(romRegsLoad, 1'b1)
		@(posedge mclk);
		fetchErr <= 1'b1;
		@(posedge mclk);
		fetchErr <= 1'b0;
		#1 `CHK(romUpdateOn, 1'b0)
		ack(1'b1, 1'b0, {1'b1, ACK_TYPE_ERR, 3'b000});
		node.reset_bus();
		#1 `CHK(romRegsLoad, 1'b0)
		wr(OFS_SET, 32'h8000_0000);
		rd(OFS_SET, 32'h0082_0000);
		wr(OFS_SET, 32'h2000_0000); // this node is never bus manager here
		ack(1'b1, 1'b0, {1'b1, ACK_TARDY, 3'b001});
		ack(1'b0, 1'b1, {1'b1, ACK_TARDY, 3'b001});
		@(posedge mclk);
		#1 `CHK(tardyEvent, 1'b0) // event is a pulse, clear before low power
		wr(OFS_CLR, 32'h0002_0000);
		ack(1'b0, 1'b1, 8'h00);
	endtask
	task automatic t_resets;
		wr(OFS_SET, 32'h8002_0000);
		@(posedge mclk);
		softReset <= 1'b1;
		@(posedge mclk);
		softReset <= 1'b0;
		rd(OFS_SET, 32'h0080_0000);
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		#1 `CHK(phyOwner, 1'b1)
		@(posedge mclk);
		eepromLoad <= 1'b1;
		@(posedge mclk);
		eepromLoad <= 1'b0;
		#1 `CHK(phyOwner, 1'b0)
		@(posedge mclk);
		global_reset_n <= 1'b0;
		repeat (6) @(posedge mclk);
		global_reset_n <= 1'b1;
		wait_owner();
		// clock enable low freezes the flags, so this write must not land
		ce <= 1'b0;
		wr(OFS_SET, 32'h4000_0000);
		ce <= 1'b1;
		rd(OFS_SET, 32'h0080_0000);
	endtask
	task automatic finish_test;
		$display("errors %0d of %0d checks", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{rst, ce, global_reset_n} = 3'b110;
		{softReset, eepromLoad, eepromOwner, regWr, regRd, fetchErr} = '0;
		regAddr = '0;
		regWrData = '0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		global_reset_n <= 1'b1;
		t_bits();
		t_link();
		t_resets();
		finish_test();
	end
endmodule
`default_nettype wire
